/* src/dual_serial_port_pkg.sv */
// shared constants and carrier types for the two-channel serial port
// assumes a single 100 MHz clock; every slower rate is an enable pulse
package dual_serial_port_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int BAUD_DEFAULT = 115200;
  localparam int DIV_DEFAULT = (CLK_MHZ * 1000000) / (BAUD_DEFAULT * 2);
  localparam int DATA_BITS = 8;
  localparam int DIV_W = 16;
  // ---------------------------------------------------------------
  // pin function select field positions (bit set = general purpose)
  // ---------------------------------------------------------------
  localparam int SEL_RX = 0;
  localparam int SEL_TX = 1;
  localparam int SEL_REQ = 2;
  localparam int SEL_PERMIT = 3;
  localparam int SEL_W = 4;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DATA_BITS-1:0] data;
  } char_s;
  typedef struct packed {
    logic tx_enable;
    logic loopback;
    logic [SEL_W-1:0] pin_function_select_b;
  } ch_ctrl_s;
endpackage

/* src/char_buffer.sv */
// two-entry valid/ready buffer for one character stream
// assumes one clock; a stall downstream never loses a word
`timescale 1ns/1ps
module char_buffer #(
  parameter int WIDTH = dual_serial_port_pkg::DATA_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_q, rd_q;
  logic [1:0] cnt_q;
  logic in_ready_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  // ready is registered so the port comes straight from a flip-flop
  assign in_ready = in_ready_q;
  assign out_valid = cnt_q != 2'h0;
  assign out_data = mem_q[rd_q];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      in_ready_q <= 1'b1;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_d;
      in_ready_q <= cnt_d != 2'h2;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule

/* src/dual_serial_port.sv */
// two independent serial channels with pin function muxing
// assumes all pin inputs are synchronous to clk; no software registers:
// control arrives on plain input ports
// frame format is fixed at 8N1: start low, eight data bits lsb first,
// stop high; the receiver samples once per bit at the serial clock rise,
// so a peripheral must move its line near the fall (no oversampling)
// the transmit pin is registered and trails the internal line by a clock
//
// How it works
// RULE_01 - two independent channels, each with receive, transmit, handshake pins
// RULE_02 - receive sampled on serial clock rising edge, least significant bit first
// RULE_03 - transmit bits launched on serial clock falling edge, lsb first
// RULE_04 - transmit pin idles high when idle or transmitter disabled
// RULE_05 - loopback holds transmit pin high, data routed internally
// RULE_06 - send request asserted when data ready, then wait for permit; in loopback the code raises no request and does not wait
// RULE_07 - transmission starts only once the peripheral grants permit; in loopback the code starts without permit
// RULE_08 - each pin selectable as general purpose, dropping serial use
// RULE_09 - send request and permit are active low on the pins
`timescale 1ns/1ps
module dual_serial_port #(
  parameter int DIV = dual_serial_port_pkg::DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  // channel control, levels
  input wire logic [1:0] tx_enable,
  input wire logic [1:0] loopback,
  input wire logic [7:0] pin_function_select_b,
  // transmit stream, one byte lane per channel
  input wire logic [15:0] tx_data,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  // receive stream
  output logic [15:0] rx_data,
  output logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  output logic [1:0] rx_frame_error,
  // pin values while a pin is general purpose
  output logic [1:0] gpi_in,
  output logic [1:0] gpi_permit,
  input wire logic [1:0] gpo_out,
  input wire logic [1:0] gpo_req,
  // serial pins
  input wire logic ch1_serial_in,
  input wire logic ch2_serial_in,
  output logic ch1_serial_out,
  output logic ch2_serial_out,
  output logic ch1_send_request_n,
  output logic ch2_send_request_n,
  input wire logic ch1_send_permit_n,
  input wire logic ch2_send_permit_n
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // the divider counter is DIV_W bits and needs two counts per half
  if (DIV < 2 || DIV >= (1 << dual_serial_port_pkg::DIV_W)) begin : g_bad_div
    $error("serial clock divider out of range");
  end
  // the frame counters below are sized for eight data bits
  if (dual_serial_port_pkg::DATA_BITS != 8) begin : g_bad_width
    $error("character width must be eight bits");
  end
  // each channel owns four pin select bits
  if (dual_serial_port_pkg::SEL_W != 4) begin : g_bad_sel
    $error("pin select field must be four bits");
  end

  // ---------------------------------------------------------------
  // serial clock source: rise and fall enables
  // ---------------------------------------------------------------
  logic [dual_serial_port_pkg::DIV_W-1:0] div_q;
  logic sclk_q;
  wire div_end = div_q == dual_serial_port_pkg::DIV_W'(DIV - 1);
  wire sclk_rise = div_end && !sclk_q;
  wire sclk_fall = div_end && sclk_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : div_q + 1'b1;
      if (div_end) sclk_q <= ~sclk_q;
    end
  end

  wire [1:0] rx_pin = {ch2_serial_in, ch1_serial_in};
  wire [1:0] permit_pin_n = {ch2_send_permit_n, ch1_send_permit_n};
  logic [1:0] tx_pin_q, req_pin_n_q, gpi_in_q, gpi_permit_q;

  assign ch1_serial_out = tx_pin_q[0];
  assign ch2_serial_out = tx_pin_q[1];
  assign ch1_send_request_n = req_pin_n_q[0];
  assign ch2_send_request_n = req_pin_n_q[1];
  assign gpi_in = gpi_in_q;
  assign gpi_permit = gpi_permit_q;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a set select bit hands the pin to general purpose use
  function automatic logic pin_is_gp(input logic [3:0] sel, input int pos);
    return sel[pos];
  endfunction

  // frame in shift order: start in bit zero, stop in bit nine
  function automatic logic [9:0] frame_of(input logic [7:0] data);
    return {1'b1, data, 1'b0};
  endfunction

  // bit counters step by one and stay inside 0 to 9
  function automatic logic [3:0] count_step(input logic [3:0] n,
                                            input logic up);
    return up ? n + 4'h1 : n - 4'h1;
  endfunction

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tx_state_e;

  // ---------------------------------------------------------------
  // per-channel logic
  // ---------------------------------------------------------------
  genvar c;
  for (c = 0; c < 2; c++) begin : g_ch // RULE_01
    dual_serial_port_pkg::ch_ctrl_s ctrl;
    assign ctrl.tx_enable = tx_enable[c];
    assign ctrl.loopback = loopback[c];
    assign ctrl.pin_function_select_b = pin_function_select_b[4*c +: 4];
    wire gp_rx = pin_is_gp(ctrl.pin_function_select_b, dual_serial_port_pkg::SEL_RX);
    wire gp_tx = pin_is_gp(ctrl.pin_function_select_b, dual_serial_port_pkg::SEL_TX);
    wire gp_req = pin_is_gp(ctrl.pin_function_select_b, dual_serial_port_pkg::SEL_REQ);
    wire gp_pm = pin_is_gp(ctrl.pin_function_select_b, dual_serial_port_pkg::SEL_PERMIT);

    // ---------------------------------------------------------------
    // transmit buffer
    // ---------------------------------------------------------------
    dual_serial_port_pkg::char_s buf_data;
    logic buf_valid, buf_pop;
    char_buffer #(.WIDTH(dual_serial_port_pkg::DATA_BITS)) u_buf (
      .clk(clk),
      .rst(rst),
      .in_data(tx_data[8*c +: 8]),
      .in_valid(tx_valid[c]),
      .in_ready(tx_ready[c]),
      .out_data(buf_data.data),
      .out_valid(buf_valid),
      .out_ready(buf_pop)
    );

    // ---------------------------------------------------------------
    // transmitter
    // ---------------------------------------------------------------
    // permit is active low; a general purpose pin never grants it
    wire permit = !gp_pm && !permit_pin_n[c]; // RULE_09 RULE_08
    tx_state_e st_q, st_d;
    logic [9:0] sh_q, sh_d;
    logic [3:0] tcnt_q, tcnt_d;
    logic line_q, line_d;
    // a disabled channel never pops, so a word is not lost on disable
    wire start_ok = st_q == TX_WAIT && sclk_fall && ctrl.tx_enable
                    && (permit || ctrl.loopback); // RULE_07
    wire tx_last = tcnt_q == 4'h0;
    assign buf_pop = start_ok;
    always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      tcnt_d = tcnt_q;
      line_d = line_q;
      case (st_q)
        TX_IDLE: begin
          line_d = 1'b1; // RULE_04
          if (buf_valid && ctrl.tx_enable) st_d = TX_WAIT;
        end
        TX_WAIT: begin
          if (!ctrl.tx_enable) begin
            st_d = TX_IDLE;
          end else if (start_ok) begin
            sh_d = frame_of(buf_data.data);
            line_d = 1'b0;
            tcnt_d = 4'h9;
            st_d = TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (sclk_fall && tx_last) begin // RULE_03
            line_d = 1'b1;
            st_d = TX_IDLE;
          end else if (sclk_fall) begin
            line_d = sh_q[1]; // RULE_03
            sh_d = {1'b1, sh_q[9:1]};
            tcnt_d = count_step(tcnt_q, 1'b0);
          end
        end
        default: st_d = TX_IDLE;
      endcase
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        st_q <= TX_IDLE;
        sh_q <= '1;
        tcnt_q <= 4'h0;
        line_q <= 1'b1;
      end else begin
        st_q <= st_d;
        sh_q <= sh_d;
        tcnt_q <= tcnt_d;
        line_q <= line_d;
      end
    end

    // ---------------------------------------------------------------
    // pin drivers: loopback and disable keep the line high
    // ---------------------------------------------------------------
    wire tx_quiet = ctrl.loopback || !ctrl.tx_enable; // RULE_05 RULE_04
    wire tx_pin_d = gp_tx ? gpo_out[c] // RULE_08
                    : (tx_quiet ? 1'b1 : line_q);
    // request is low only while a word waits for the peripheral
    wire asking = st_q == TX_WAIT && !ctrl.loopback; // RULE_06
    wire req_pin_n_d = gp_req ? gpo_req[c] : !asking; // RULE_08 RULE_09
    wire gpi_in_d = gp_rx ? rx_pin[c] : 1'b0; // RULE_08
    wire gpi_permit_d = gp_pm ? permit_pin_n[c] : 1'b0; // RULE_08
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        tx_pin_q[c] <= 1'b1;
        req_pin_n_q[c] <= 1'b1;
        gpi_in_q[c] <= 1'b0;
        gpi_permit_q[c] <= 1'b0;
      end else begin
        tx_pin_q[c] <= tx_pin_d;
        req_pin_n_q[c] <= req_pin_n_d;
        gpi_in_q[c] <= gpi_in_d;
        gpi_permit_q[c] <= gpi_permit_d;
      end
    end

    // ---------------------------------------------------------------
    // receiver: one sample per bit, at the rise in the middle of it
    // ---------------------------------------------------------------
    wire rx_line = ctrl.loopback ? line_q
                   : (gp_rx ? 1'b1 : rx_pin[c]); // RULE_05 RULE_08
    logic rx_busy_q, rx_busy_d;
    logic [3:0] rcnt_q, rcnt_d;
    logic [7:0] rsh_q, rsh_d;
    logic [7:0] rx_data_q, rx_data_d;
    logic rx_valid_q, rx_valid_d;
    logic rx_ferr_q, rx_ferr_d;
    wire rx_start = sclk_rise && !rx_busy_q && !rx_line;
    wire rx_stop = sclk_rise && rx_busy_q && rcnt_q == 4'h8;
    wire rx_bit = sclk_rise && rx_busy_q && rcnt_q != 4'h8; // RULE_02
    assign rx_data[8*c +: 8] = rx_data_q;
    assign rx_valid[c] = rx_valid_q;
    assign rx_frame_error[c] = rx_ferr_q;
    always_comb begin
      rx_busy_d = rx_busy_q;
      rcnt_d = rcnt_q;
      rsh_d = rsh_q;
      rx_data_d = rx_data_q;
      // a new word wins over the reader's take in the same cycle
      rx_valid_d = rx_valid_q && !rx_ready[c];
      rx_ferr_d = 1'b0;
      if (rx_start) begin // RULE_02
        rx_busy_d = 1'b1;
        rcnt_d = 4'h0;
      end
      if (rx_bit) begin
        rsh_d = {rx_line, rsh_q[7:1]}; // RULE_02
        rcnt_d = count_step(rcnt_q, 1'b1);
      end
      if (rx_stop) begin
        rx_busy_d = 1'b0;
        rx_data_d = rx_line ? rsh_q : rx_data_q;
        rx_valid_d = rx_line || rx_valid_d;
        rx_ferr_d = !rx_line;
      end
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rx_busy_q <= 1'b0;
        rcnt_q <= 4'h0;
        rsh_q <= '0;
        rx_data_q <= '0;
        rx_valid_q <= 1'b0;
        rx_ferr_q <= 1'b0;
      end else begin
        rx_busy_q <= rx_busy_d;
        rcnt_q <= rcnt_d;
        rsh_q <= rsh_d;
        rx_data_q <= rx_data_d;
        rx_valid_q <= rx_valid_d;
        rx_ferr_q <= rx_ferr_d;
      end
    end
  end
endmodule

/* tb/serial_peer.sv */
// peripheral model: echoes the device line back, grants permit after a lag
// assumes the same clock as the device; LAG of 1 is prompt, larger is slow
`timescale 1ns/1ps
module serial_peer #(
  parameter int LAG = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_out,
  input wire logic send_request_n,
  output logic serial_in,
  output logic send_permit_n
);
  logic [15:0] req_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= 16'hFFFF;
      serial_in <= 1'h1;
    end else begin
      req_q <= {req_q[14:0], send_request_n};
      serial_in <= serial_out;
    end
  end
  // permit follows the low-active request, so it never comes unasked
  assign send_permit_n = req_q[LAG-1];
endmodule

/* tb/dual_serial_port_checker.sv */
// timing checks on channel one pins of the two-channel serial port
// assumes one clock and the async high reset of the top module
`timescale 1ns/1ps
module dual_serial_port_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] tx_enable,
  input wire logic [1:0] loopback,
  input wire logic [7:0] pin_function_select_b,
  input wire logic [1:0] gpo_out,
  input wire logic [1:0] gpo_req,
  input wire logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  input wire logic [1:0] gpi_in,
  input wire logic ch1_serial_in,
  input wire logic ch1_serial_out,
  input wire logic ch1_send_request_n,
  input wire logic ch1_send_permit_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence asked_not_granted;
    !ch1_send_request_n && ch1_send_permit_n && !loopback[0] &&
      !pin_function_select_b[1];
  endsequence
  a_wait_permit: assert property (asked_not_granted |=> ch1_serial_out)
    else $error("line left idle before permit");
  a_gp_tx: assert property (pin_function_select_b[1] &&
    $past(pin_function_select_b[1]) |-> ch1_serial_out == $past(gpo_out[0]))
    else $error("tx pin not general purpose");
  a_gp_req: assert property (pin_function_select_b[2] &&
    $past(pin_function_select_b[2]) |->
    ch1_send_request_n == $past(gpo_req[0]))
    else $error("request pin not general purpose");
  a_gp_in: assert property (pin_function_select_b[0] &&
    $past(pin_function_select_b[0]) |-> gpi_in[0] == $past(ch1_serial_in))
    else $error("rx pin value not passed on");
  a_loop_out: assert property (loopback[0] && $past(loopback[0]) &&
    $past(!pin_function_select_b[1]) |-> ch1_serial_out)
    else $error("loopback drove the line");
  a_loop_req: assert property (loopback[0] && $past(loopback[0]) &&
    $past(!pin_function_select_b[2]) |-> ch1_send_request_n)
    else $error("loopback raised a request");
  a_off_idle: assert property (!tx_enable[0] && $past(!tx_enable[0]) &&
    $past(!pin_function_select_b[1]) |-> ch1_serial_out)
    else $error("disabled line not high");
  a_rx_hold: assert property (rx_valid[0] && !rx_ready[0] |=> rx_valid[0])
    else $error("received word dropped");
endmodule

/* tb/dual_serial_port_bench.sv */
// self-checking bench: both channels, loopback, disable and pin muxing
// assumes DIV of 4 so one bit stands 8 clocks
`timescale 1ns/1ps
module dual_serial_port_bench;
  localparam int DIV = 4;
  logic clk = 1'h0, rst = 1'h1;
  logic [1:0] tx_enable = 2'h3, loopback = 2'h0, tx_valid = 2'h0;
  logic [1:0] rx_ready = 2'h3, gpo_out = 2'h3, gpo_req = 2'h3;
  logic [1:0] tx_ready, rx_valid, rx_err, gpi_in, gpi_permit;
  logic [7:0] sel = 8'h00;
  logic [15:0] tx_data = 16'h0000, rx_data;
  logic s1_in, s2_in, s1_out, s2_out, r1_n, r2_n, p1_n, p2_n;
  logic [7:0] exp_rx [2][$];
  logic [7:0] exp_tx [$];
  logic [31:0] lfsr = 32'hCB79;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  dual_serial_port #(.DIV(DIV)) dut (.clk(clk), .rst(rst),
    .tx_enable(tx_enable), .loopback(loopback),
    .pin_function_select_b(sel), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_frame_error(rx_err), .gpi_in(gpi_in),
    .gpi_permit(gpi_permit), .gpo_out(gpo_out), .gpo_req(gpo_req),
    .ch1_serial_in(s1_in), .ch2_serial_in(s2_in), .ch1_serial_out(s1_out),
    .ch2_serial_out(s2_out), .ch1_send_request_n(r1_n),
    .ch2_send_request_n(r2_n), .ch1_send_permit_n(p1_n),
    .ch2_send_permit_n(p2_n));
  serial_peer #(.LAG(1)) peer1 (.clk(clk), .rst(rst), .serial_out(s1_out),
    .send_request_n(r1_n), .serial_in(s1_in), .send_permit_n(p1_n));
  serial_peer #(.LAG(9)) peer2 (.clk(clk), .rst(rst), .serial_out(s2_out),
    .send_request_n(r2_n), .serial_in(s2_in), .send_permit_n(p2_n));
  always #5 clk = ~clk;
  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h80200003 : 32'h0);
  endfunction
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic send(input int c);
    logic [7:0] d;
    logic ok;
    d = lfsr[7:0];
    @(posedge clk);
    // notes are made at the edge, where a loopback change has landed
    exp_rx[c].push_back(d);
    if (c == 0 && loopback[0] === 1'h0) exp_tx.push_back(d);
    tx_data[8*c+:8] <= d;
    tx_valid[c] <= 1'h1;
    // a full buffer refuses: hold the word until an edge takes it
    do begin
      @(negedge clk);
      ok = tx_ready[c];
      @(posedge clk);
    end while (ok !== 1'h1);
    tx_valid[c] <= 1'h0;
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && exp_rx[0].size() + exp_rx[1].size() > 0; i++)
      @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // monitors
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lfsr <= step(lfsr);
    rx_ready <= lfsr[9:8] | lfsr[3:2];
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
    for (int c = 0; c < 2; c++) begin
      if (rst === 1'h0 && rx_err[c] !== 1'h0)
        chk({7'h00, rx_err[c]}, 8'h00);
      if (rx_valid[c] === 1'h1 && rx_ready[c] === 1'h1)
        chk(rx_data[8*c+:8], exp_rx[c].pop_front());
    end
  end
  initial forever begin : line_watch
    logic [7:0] got;
    @(negedge s1_out);
    if (sel[1] === 1'h0) begin
      repeat (DIV) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (2 * DIV) @(posedge clk);
        got[i] = s1_out;
      end
      repeat (2 * DIV) @(posedge clk);
      chk({7'h00, s1_out}, 8'h01);
      chk(got, exp_tx.pop_front());
    end
  end
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    chk({6'h00, tx_ready}, 8'h03);
    fork
      repeat (3) send(0);
      repeat (3) send(1);
    join
    drain();
    loopback <= 2'h1;
    send(0);
    drain();
    loopback <= 2'h0;
    tx_enable <= 2'h0;
    repeat (20) @(posedge clk);
    tx_enable <= 2'h3;
    sel <= 8'hFF;
    // random pin values while every pin is general purpose
    repeat (40) begin
      @(posedge clk);
      gpo_out <= lfsr[5:4];
      gpo_req <= lfsr[7:6];
    end
    gpo_out <= 2'h3;
    gpo_req <= 2'h3;
    repeat (14) @(posedge clk);
    chk({6'h00, gpi_in}, 8'h03);
    chk({6'h00, gpi_permit}, 8'h03);
    sel <= 8'h00;
    repeat (4) @(posedge clk);
    fork
      send(0);
      send(1);
    join
    drain();
    repeat (20) @(posedge clk);
    // words still noted were never seen on the line or the receiver
    chk(8'(exp_rx[0].size() + exp_rx[1].size() + exp_tx.size()), 8'h00);
    finish_test();
  end
endmodule
bind dual_serial_port dual_serial_port_checker chk_i (.clk(clk), .rst(rst),
  .tx_enable(tx_enable), .loopback(loopback),
  .pin_function_select_b(pin_function_select_b), .gpo_out(gpo_out),
  .gpo_req(gpo_req), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .gpi_in(gpi_in), .ch1_serial_in(ch1_serial_in),
  .ch1_serial_out(ch1_serial_out), .ch1_send_request_n(ch1_send_request_n),
  .ch1_send_permit_n(ch1_send_permit_n));
